// file: core/pack_pkg.sv
// Types and constants shared by the raw colour twelve-bit pair packer
package pack_pkg;

    // ****************************************
    // Widths and field positions
    // ****************************************
    localparam int SAMPLE_W = 12; // Raw sample width, unsigned 0x000 to 0xFFF
    localparam int BYTE_W = 8;
    localparam int HIGH_MSB = 11; // High part of a sample sits in bits 11..4
    localparam int HIGH_LSB = 4;
    localparam int LOW_MSB = 3; // Low nibble of a sample sits in bits 3..0
    localparam int LOW_LSB = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 12'h000;
    localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
    localparam logic [SAMPLE_W-1:0] SAMPLE_MAX = 12'hFFF; // Signal level 4095

    // Filter colour of the pixel whose bits a byte carries
    typedef enum logic [1:0] {
        COLOUR_BLUE,
        COLOUR_GREEN,
        COLOUR_RED
    } filter_colour_t;

    // Pixel word from the sensor side
    typedef struct packed {
        logic [SAMPLE_W-1:0] sample;
        logic frame_start; // First pixel of a frame
        logic row_end; // Last pixel of a row
    } pixel_word_t;

    // Byte word towards the host link
    typedef struct packed {
        logic [BYTE_W-1:0] data;
        filter_colour_t colour;
        logic row_odd;
        logic first_byte_of_row;
        logic last_byte_of_row;
    } packed_byte_t;

endpackage : pack_pkg

// file: core/raw_color_12bit_pair_packer.sv
// Packer for the raw colour twelve-bit packed byte stream
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Each pixel yields exactly twelve data bits, no padding between pixels.
// - Every two consecutive pixels travel in exactly three consecutive bytes.
// - Samples are passed raw, never interpolated or altered.
// - Packing restarts at each row; first and last bytes belong to row ends.
// - Group byte one carries bits 11..4 of the earlier pixel.
// - Byte two carries later low nibble high, earlier low nibble low.
// - Group byte three carries bits 11..4 of the later pixel.
// - Even rows: blue at even positions, green at odd, blue first.
// - Odd rows: green at even positions, red at odd, green first.
// - Pixel values are unsigned twelve bits, 0x000 to 0xFFF.
module raw_color_12bit_pair_packer (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic pix_valid,
    output logic pix_ready,
    input wire pack_pkg::pixel_word_t pix_in,
    output logic byte_valid,
    input wire logic byte_ready,
    output pack_pkg::packed_byte_t byte_out
);
    import pack_pkg::*;

    // ****************************************
    // Types and functions
    // ****************************************
    typedef enum logic [2:0] {
        GET_EARLY,
        GET_LATE,
        SEND_B0,
        SEND_B1,
        SEND_B2
    } pack_state_t;

    // Filter colour from row parity and pixel position parity
    function automatic filter_colour_t colour_of(input logic odd_row, input logic odd_pos);
        if (!odd_row) begin
            colour_of = odd_pos ? COLOUR_GREEN : COLOUR_BLUE;
        end else begin
            colour_of = odd_pos ? COLOUR_RED : COLOUR_GREEN;
        end
    endfunction : colour_of

    // High and low parts of a raw sample
    function automatic logic [BYTE_W-1:0] high_part(input logic [SAMPLE_W-1:0] s);
        high_part = s[HIGH_MSB:HIGH_LSB];
    endfunction : high_part

    function automatic logic [LOW_MSB:LOW_LSB] low_part(input logic [SAMPLE_W-1:0] s);
        low_part = s[LOW_MSB:LOW_LSB];
    endfunction : low_part

    // ****************************************
    // State
    // ****************************************
    pack_state_t state_r, state_nxt;
    logic [SAMPLE_W-1:0] early_r, early_nxt;
    logic [SAMPLE_W-1:0] late_r, late_nxt;
    logic row_odd_r, row_odd_nxt; // Parity of the row being received
    logic row_fresh_r, row_fresh_nxt; // Next pixel starts a row
    logic pair_odd_r, pair_odd_nxt; // Row parity of the pair in flight
    logic pair_first_r, pair_first_nxt; // Pair opens its row
    logic pair_last_r, pair_last_nxt; // Pair closes its row
    packed_byte_t out_r, out_nxt;
    logic take;
    logic give;
    logic this_odd;

    // Handshakes: pixels only taken between groups, bytes only offered inside one
    assign pix_ready = (state_r == GET_EARLY) || (state_r == GET_LATE);
    assign byte_valid = (state_r == SEND_B0) || (state_r == SEND_B1) || (state_r == SEND_B2);
    assign byte_out = out_r;
    assign take = pix_valid && pix_ready;
    assign give = byte_valid && byte_ready;
    // A frame start forces row zero, which is even
    assign this_odd = pix_in.frame_start ? 1'b0 : row_odd_r;

    // ****************************************
    // Next-state logic
    // ****************************************
    // Collect a pair, then hand out its three bytes in ascending order
    always_comb begin
        state_nxt = state_r;
        early_nxt = early_r;
        late_nxt = late_r;
        row_odd_nxt = row_odd_r;
        row_fresh_nxt = row_fresh_r;
        pair_odd_nxt = pair_odd_r;
        pair_first_nxt = pair_first_r;
        pair_last_nxt = pair_last_r;
        out_nxt = out_r;
        // Row bookkeeping on every accepted pixel
        if (take) begin
            row_fresh_nxt = pix_in.row_end;
            row_odd_nxt = pix_in.row_end ? !this_odd : this_odd;
        end
        case (state_r)
            GET_EARLY: begin
                if (take) begin
                    early_nxt = pix_in.sample;
                    pair_odd_nxt = this_odd;
                    pair_first_nxt = row_fresh_r || pix_in.frame_start;
                    pair_last_nxt = pix_in.row_end;
                    if (pix_in.row_end) begin
                        // Odd-length row: close the group with a zero later pixel
                        late_nxt = SAMPLE_RST;
                        out_nxt.data = high_part(pix_in.sample);
                        out_nxt.colour = colour_of(this_odd, 1'b0);
                        out_nxt.row_odd = this_odd;
                        out_nxt.first_byte_of_row = row_fresh_r || pix_in.frame_start;
                        out_nxt.last_byte_of_row = 1'b0;
                        state_nxt = SEND_B0;
                    end else begin
                        state_nxt = GET_LATE;
                    end
                end
            end
            GET_LATE: begin
                if (take) begin
                    late_nxt = pix_in.sample;
                    pair_last_nxt = pix_in.row_end;
                    out_nxt.data = high_part(early_r);
                    out_nxt.colour = colour_of(pair_odd_r, 1'b0);
                    out_nxt.row_odd = pair_odd_r;
                    out_nxt.first_byte_of_row = pair_first_r;
                    out_nxt.last_byte_of_row = 1'b0;
                    state_nxt = SEND_B0;
                end
            end
            SEND_B0: begin
                if (give) begin
                    out_nxt.data = {low_part(late_r), low_part(early_r)};
                    out_nxt.colour = colour_of(pair_odd_r, 1'b1);
                    out_nxt.first_byte_of_row = 1'b0;
                    out_nxt.last_byte_of_row = 1'b0;
                    state_nxt = SEND_B1;
                end
            end
            SEND_B1: begin
                if (give) begin
                    out_nxt.data = high_part(late_r);
                    out_nxt.colour = colour_of(pair_odd_r, 1'b1);
                    out_nxt.last_byte_of_row = pair_last_r;
                    state_nxt = SEND_B2;
                end
            end
            SEND_B2: begin
                if (give) begin
                    out_nxt.last_byte_of_row = 1'b0;
                    state_nxt = GET_EARLY;
                end
            end
            default: begin
                state_nxt = GET_EARLY;
            end
        endcase
    end

    // ****************************************
    // Registers
    // ****************************************
    // Synchronous active-low reset to an empty pipe at row zero
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r <= GET_EARLY;
            early_r <= SAMPLE_RST;
            late_r <= SAMPLE_RST;
            row_odd_r <= 1'b0;
            row_fresh_r <= 1'b1;
            pair_odd_r <= 1'b0;
            pair_first_r <= 1'b0;
            pair_last_r <= 1'b0;
            out_r <= '{data: BYTE_RST, colour: COLOUR_BLUE, row_odd: 1'b0,
                       first_byte_of_row: 1'b0, last_byte_of_row: 1'b0};
        end else begin
            state_r <= state_nxt;
            early_r <= early_nxt;
            late_r <= late_nxt;
            row_odd_r <= row_odd_nxt;
            row_fresh_r <= row_fresh_nxt;
            pair_odd_r <= pair_odd_nxt;
            pair_first_r <= pair_first_nxt;
            pair_last_r <= pair_last_nxt;
            out_r <= out_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Checks sample on the pixel clock and rest while reset is low
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    // ****************************************
    // Byte layout within a group
    // ****************************************
    // Earlier pixel high bits open the group
    a_early_high_byte: assert property (
        (state_r == GET_LATE && take)
        |=> byte_valid && byte_out.data == early_r[HIGH_MSB:HIGH_LSB]
    ) else $error("first group byte is not the earlier pixel high bits");

    // Both low nibbles share the middle byte, later pixel on top
    a_middle_nibbles: assert property (
        (state_r == SEND_B0 && give)
        |=> byte_out.data == {late_r[LOW_MSB:LOW_LSB], early_r[LOW_MSB:LOW_LSB]}
    ) else $error("middle group byte nibbles misplaced");

    // Later pixel high bits close the group
    a_late_high_byte: assert property (
        (state_r == SEND_B1 && give) |=> byte_out.data == late_r[HIGH_MSB:HIGH_LSB]
    ) else $error("third group byte is not the later pixel high bits");

    // Samples are captured bit for bit
    a_raw_sample_kept: assert property (
        (state_r == GET_LATE && take) |=> late_r == $past(pix_in.sample)
    ) else $error("later sample altered on capture");

    a_early_sample_kept: assert property (
        (state_r == GET_EARLY && take) |=> early_r == $past(pix_in.sample)
    ) else $error("earlier sample altered on capture");

    // ****************************************
    // Group handshake
    // ****************************************
    // A pair taken at full speed leaves in exactly three bytes
    a_three_bytes_group: assert property (
        (state_r == GET_LATE && take) ##1 (byte_valid && byte_ready) [*3]
        |=> pix_ready && !byte_valid
    ) else $error("pair did not take exactly three bytes");

    // No pixel is accepted while a group is open
    a_no_pad_overlap: assert property (
        pix_ready |-> !byte_valid && state_r != SEND_B2
    ) else $error("pixel accepted while a group is still open");

    // A stalled byte and its flags stand until the host takes it
    a_bytes_hold_stall: assert property (
        (byte_valid && !byte_ready) |=> byte_valid && $stable(byte_out)
    ) else $error("offered byte changed before it was taken");

    // The third byte taken reopens the pixel side
    a_ready_after_group: assert property (
        (state_r == SEND_B2 && give) |=> pix_ready && !byte_valid
    ) else $error("pixel side not reopened after the third byte");

    // ****************************************
    // Row framing and colour order
    // ****************************************
    // Row edge flags only on the outer bytes of a group
    a_row_edge_bytes: assert property (
        byte_valid && (byte_out.first_byte_of_row || byte_out.last_byte_of_row)
        |-> (byte_out.first_byte_of_row ? state_r == SEND_B0 : state_r == SEND_B2)
    ) else $error("row edge marked on the wrong byte of a group");

    // A frame start on a back-to-back pair marks the row's first byte
    a_frame_first_byte: assert property (
        (state_r == GET_EARLY && take && pix_in.frame_start && !pix_in.row_end)
        ##1 (state_r == GET_LATE && take)
        |=> byte_out.first_byte_of_row
    ) else $error("frame start pair lost its first byte flag");

    // A row end on the later pixel marks the third byte as the row's last
    a_row_end_last_byte: assert property (
        (state_r == GET_LATE && take && pix_in.row_end) ##1 (give) [*2]
        |=> byte_out.last_byte_of_row
    ) else $error("row end pair lost its last byte flag");

    // Even rows: blue first, green after
    a_even_row_colour: assert property (
        byte_valid && !byte_out.row_odd
        |-> byte_out.colour == ((state_r == SEND_B0) ? COLOUR_BLUE : COLOUR_GREEN)
    ) else $error("even row colour order broken");

    // Odd rows: green first, red after
    a_odd_row_colour: assert property (
        byte_valid && byte_out.row_odd
        |-> byte_out.colour == ((state_r == SEND_B0) ? COLOUR_GREEN : COLOUR_RED)
    ) else $error("odd row colour order broken");

    // A frame start resets the row count to zero
    a_frame_row_zero: assert property (
        (state_r == GET_EARLY && take && pix_in.frame_start) |=> !pair_odd_r
    ) else $error("frame did not start on an even row");

    // A row end flips the parity unless a frame start pins it
    a_row_parity_flip: assert property (
        (take && pix_in.row_end && !pix_in.frame_start) |=> row_odd_r != $past(row_odd_r)
    ) else $error("row parity did not toggle at the end of a row");

    // Sample values stay within twelve unsigned bits
    a_sample_in_range: assert property (
        (state_r == GET_LATE && take) |=> early_r <= SAMPLE_MAX && late_r <= SAMPLE_MAX
    ) else $error("sample outside twelve-bit range");

endmodule : raw_color_12bit_pair_packer

`default_nettype wire

// file: tb/host_sink.sv
// Host-side model that takes packed bytes, with an optional stall pattern
`timescale 1ns/1ps
`default_nettype none
module host_sink (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic byte_valid,
    output logic byte_ready,
    input wire pack_pkg::packed_byte_t byte_out
);
    import pack_pkg::*;
    packed_byte_t got[$];
    logic [1:0] cnt_r;
    // ****************************************
    // Stall pattern
    // ****************************************
    // Free-running count; when slow, ready only one cycle in four
    always @(posedge sys_clk) begin
        if (!nrst)
            cnt_r <= 2'h0;
        else
            cnt_r <= cnt_r + 2'h1;
    end
    assign byte_ready = !slow || (cnt_r == 2'h3);
    // ****************************************
    // Byte capture
    // ****************************************
    // Store each byte taken; sample parts are read as unsigned values
    always @(posedge sys_clk) begin
        if (nrst && byte_valid && byte_ready) begin
            got.push_back(byte_out);
        end
    end
endmodule : host_sink
`default_nettype wire

// file: tb/raw_color_12bit_pair_packer_tb.sv
// Self-checking testbench for the raw colour twelve-bit pair packer
`timescale 1ns/1ps
`default_nettype none
module raw_color_12bit_pair_packer_tb;
    import pack_pkg::*;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic pix_valid = 1'b0;
    logic slow = 1'b0;
    pixel_word_t pix_in = '0;
    logic pix_ready;
    logic byte_valid;
    logic byte_ready;
    packed_byte_t byte_out;
    int error_cnt = 0;
    int checks_done = 0;

    // ****************************************
    // Clock, design and host model
    // ****************************************
    always #4 sys_clk = ~sys_clk;
    raw_color_12bit_pair_packer DUT (.sys_clk(sys_clk), .nrst(nrst), .pix_valid(pix_valid),
        .pix_ready(pix_ready), .pix_in(pix_in), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .byte_out(byte_out));
    host_sink host (.sys_clk(sys_clk), .nrst(nrst), .slow(slow), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .byte_out(byte_out));

    // ****************************************
    // Checking and closing
    // ****************************************
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    // No new pixel is accepted while a group's bytes are outstanding
    always @(negedge sys_clk) begin
        if (nrst && byte_valid === 1'b1) chk("ready during group", pix_ready, 16'h0);
    end

    // ****************************************
    // Drivers and scenarios
    // ****************************************
    // Offer one pixel and hold it until the edge that takes it
    task automatic put_pix(input logic [11:0] s, input logic fs, input logic re);
        pix_valid <= 1'b1;
        pix_in <= '{sample: s, frame_start: fs, row_end: re};
        @(posedge sys_clk);
        while (pix_ready !== 1'b1) @(posedge sys_clk);
    endtask : put_pix

    // Send a four-pixel row back to back and judge the six bytes received
    task automatic run_row(input logic fs, input logic odd, input logic slw,
        input logic [11:0] v0, input logic [11:0] v1, input logic [11:0] v2,
        input logic [11:0] v3);
        logic [11:0] v[4];
        logic [11:0] e;
        logic [11:0] l;
        packed_byte_t b[3];
        int k;
        v = '{v0, v1, v2, v3};
        slow <= slw;
        host.got.delete();
        for (int i = 0; i < 4; i++) put_pix(v[i], fs && (i == 0), i == 3);
        pix_valid <= 1'b0;
        k = 0;
        while (host.got.size() < 6 && k < 200) begin
            @(posedge sys_clk);
            k++;
        end
        chk("byte count", 16'(host.got.size()), 16'h6);
        for (int g = 0; g < 2; g++) begin
            e = v[2 * g];
            l = v[2 * g + 1];
            for (int j = 0; j < 3; j++) b[j] = host.got[3 * g + j];
            chk("byte0 data", b[0].data, e[11:4]);
            chk("byte1 data", b[1].data, {l[3:0], e[3:0]});
            chk("byte2 data", b[2].data, l[11:4]);
            chk("early colour", b[0].colour, odd ? COLOUR_GREEN : COLOUR_BLUE);
            chk("middle colour", b[1].colour, odd ? COLOUR_RED : COLOUR_GREEN);
            chk("later colour", b[2].colour, odd ? COLOUR_RED : COLOUR_GREEN);
            for (int j = 0; j < 3; j++) begin
                chk("row parity", b[j].row_odd, odd);
                chk("first flag", b[j].first_byte_of_row, g == 0 && j == 0);
                chk("last flag", b[j].last_byte_of_row, g == 1 && j == 2);
            end
        end
    endtask : run_row

    // ****************************************
    // Scenarios
    // ****************************************
    // Idle outputs at the first edges after a reset release
    task automatic scen_reset_idle();
        @(negedge sys_clk);
        chk("ready after reset", pix_ready, 16'h1);
        chk("valid after reset", byte_valid, 16'h0);
        chk("byte after reset", byte_out, 16'h0);
        @(posedge sys_clk);
    endtask : scen_reset_idle

    // Even row with extreme values, fast host
    task automatic scen_even_row();
        run_row(1'b1, 1'b0, 1'b0, 12'hABC, 12'h123, 12'hFFF, 12'h000);
    endtask : scen_even_row

    // Frame start right after an even row pins the next row even
    task automatic scen_frame_restart();
        run_row(1'b1, 1'b0, 1'b0, 12'h0F0, 12'hF0F, 12'h876, 12'h789);
    endtask : scen_frame_restart

    // Odd row with a stalling host
    task automatic scen_odd_stalled();
        run_row(1'b0, 1'b1, 1'b1, 12'h5A5, 12'hA5A, 12'h001, 12'hFFE);
    endtask : scen_odd_stalled

    // Reset with a group open on an odd row: outputs idle, next row even and fresh
    task automatic scen_mid_reset();
        slow <= 1'b1;
        put_pix(12'h321, 1'b0, 1'b0);
        put_pix(12'h654, 1'b0, 1'b0);
        pix_valid <= 1'b0;
        @(negedge sys_clk);
        chk("group open before reset", byte_valid, 16'h1);
        @(posedge sys_clk);
        nrst <= 1'b0;
        @(posedge sys_clk);
        nrst <= 1'b1;
        scen_reset_idle();
        run_row(1'b0, 1'b0, 1'b0, 12'h9C3, 12'h3C9, 12'h7E1, 12'h1E7);
    endtask : scen_mid_reset

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        repeat (3) @(posedge sys_clk);
        nrst <= 1'b1;
        scen_reset_idle();
        scen_even_row();
        scen_frame_restart();
        scen_mid_reset();
        scen_odd_stalled();
        test_done();
    end

    initial begin
        #(2500 * 8);
        error_cnt++;
        test_done();
    end
endmodule : raw_color_12bit_pair_packer_tb
`default_nettype wire
